// file: include/mas_pkg.sv
// Purpose: Shared constants and types for the modem front-end serial port
// Assumes: 16-bit words on the link, 5-bit register addresses
// Notes: Control field positions are fixed here for all files

package mas_pkg;

  // ===========================================================
  // Word format
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 5;
  localparam int RW_BIT = 15;
  localparam logic [4:0] BIT_COUNT = 5'h10;

  // ===========================================================
  // Register addresses
  localparam logic [4:0] ADDR_CTRL0 = 5'h00;
  localparam logic [4:0] ADDR_CTRL1 = 5'h01;
  localparam logic [4:0] ADDR_CTRL2 = 5'h02;
  localparam logic [4:0] ADDR_CTRL3 = 5'h03;
  localparam logic [4:0] ADDR_CTRL4 = 5'h04;
  localparam logic [4:0] ADDR_CTRL5 = 5'h05;
  localparam logic [4:0] ADDR_DAC_IN = 5'h06;
  localparam logic [4:0] ADDR_INTERP_IN = 5'h07;
  localparam logic [4:0] ADDR_ADC_OUT = 5'h08;
  localparam logic [4:0] ADDR_INTERP_OUT = 5'h09;
  localparam logic [4:0] ADDR_RESERVED = 5'h0A;

  // ===========================================================
  // Reset value and field positions
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int OP_LSB = 0;
  localparam int OP_BITS = 3;
  localparam int OP_V32_BIT = 2;
  localparam int SR_LSB = 3;
  localparam int SR_BITS = 2;
  localparam int TS_LSB = 5;
  localparam int TS_BITS = 4;
  localparam int FB_LSB = 0;
  localparam int FB_BITS = 3;
  localparam int ANALOG_POWERDOWN_RELEASE_BIT = 3;
  localparam int DIGITAL_POWERDOWN_RELEASE_BIT = 4;
  localparam int RATE_SCALE_EIGHT_SEVENTHS_BIT = 5;
  localparam logic [15:0] MODE_LOW_MASK = 16'h0003;

  // ===========================================================
  // Types
  typedef struct packed {
    logic [15:0] transmit_phase_adjust;
    logic [15:0] receive_phase_adjust;
    logic [15:0] transmit_bit_baud_select;
    logic [15:0] receive_bit_baud_select;
    logic [15:0] bypass_powerdown_config;
    logic [15:0] rate_and_mode_config;
  } mas_ctrl_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } mas_sample_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ADDR = 2'b01,
    TX_DATA = 2'b10
  } mas_tx_state_type;

  typedef enum logic [1:0] {
    SRC_READ = 2'b00,
    SRC_ADC = 2'b01,
    SRC_INTERP = 2'b10
  } mas_src_type;

endpackage

// file: hw/mas_word_rx.sv
// Purpose: Receives one 16-bit word per incoming frame sync
// Assumes: fall marks a sampled falling edge of the serial clock
// Notes: Back-to-back words allowed when sync comes with the last bit
`timescale 1ns/1ps

module mas_word_rx
  import mas_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link side, already synchronised
  input wire logic fall,
  input wire logic serial_in_line,
  input wire logic fs,
  // Word side
  output mas_sample_type word
);

  // ===========================================================
  // Shift register
  logic [4:0] count;
  logic [4:0] next_count;
  logic [15:0] shift;
  logic [15:0] next_shift;
  mas_sample_type next_word;

  always_comb begin
    next_count = count;
    next_shift = shift;
    next_word = word;
    next_word.valid = 1'b0;
    if (fall) begin
      if (count == 5'h00) begin
        if (fs) begin
          next_count = BIT_COUNT;
        end
      end else begin
        next_shift = {shift[14:0], serial_in_line};
        next_count = count - 5'h01;
        if (count == 5'h01) begin
          next_word = '{1'b1, {shift[14:0], serial_in_line}};
          if (fs) begin
            next_count = BIT_COUNT;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 5'h00;
      shift <= 16'h0000;
      word <= '{1'b0, 16'h0000};
    end else begin
      count <= next_count;
      shift <= next_shift;
      word <= next_word;
    end
  end

  // ===========================================================
  // Checks
  property p_sync_ignored;
    @(posedge clk) disable iff (reset)
    (fall && count > 5'h01) |=> (count == $past(count) - 5'h01);
  endproperty
  a_sync_ignored: assert property (p_sync_ignored)
    else $error("frame sync restarted a word mid-reception");

endmodule

// file: hw/mas_word_tx.sv
// Purpose: Sends one 16-bit word after a one-cycle frame sync
// Assumes: rise marks a sampled rising edge of the serial clock
// Notes: load is taken whenever it is high; callers give it only while ready is high
`timescale 1ns/1ps

module mas_word_tx
  import mas_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Word side
  input wire logic rise,
  input wire logic load,
  input wire logic [15:0] word,
  output logic ready,
  // Link side
  output logic serial_out_line,
  output logic serial_out_frame_sync
);

  // ===========================================================
  // Serializer
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [4:0] count;
  logic [4:0] next_count;
  logic pending;
  logic next_pending;
  logic next_sdo;
  logic next_serial_out_frame_sync;

  assign ready = ~pending & (count == 5'h00);

  always_comb begin
    next_shift = shift;
    next_count = count;
    next_pending = pending;
    next_sdo = serial_out_line;
    next_serial_out_frame_sync = serial_out_frame_sync;
    if (load) begin
      next_shift = word;
      next_pending = 1'b1;
    end
    if (rise) begin
      if (pending) begin
        next_serial_out_frame_sync = 1'b1;
        next_count = BIT_COUNT;
        next_pending = 1'b0;
      end else if (count != 5'h00) begin
        next_serial_out_frame_sync = 1'b0;
        next_sdo = shift[15];
        next_shift = {shift[14:0], 1'b0};
        next_count = count - 5'h01;
      end else begin
        next_serial_out_frame_sync = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shift <= 16'h0000;
      count <= 5'h00;
      pending <= 1'b0;
      serial_out_line <= 1'b0;
      serial_out_frame_sync <= 1'b0;
    end else begin
      shift <= next_shift;
      count <= next_count;
      pending <= next_pending;
      serial_out_line <= next_sdo;
      serial_out_frame_sync <= next_serial_out_frame_sync;
    end
  end

  // ===========================================================
  // Checks
  property p_sync_then_msb;
    @(posedge clk) disable iff (reset)
    (rise && pending) |=> serial_out_frame_sync ##1 (!rise [*1]) ##0 (count == BIT_COUNT);
  endproperty
  a_sync_then_msb: assert property (p_sync_then_msb)
    else $error("frame sync not raised one bit cycle ahead of a word");

endmodule

// file: hw/mas_serial_port.sv
// Purpose: Serial register port of a modem analog front end
// Assumes: Host drives serial clock, frame sync and data on pins
// Notes: All three link input pins pass two flops before use; edges found on SYS_CLK
//
// Summary of operation
// - Soft reset restarts processing and leaves control registers alone
// - Rate, sync-rate, bypass or 8/7 change while running gives soft reset
// - Mode change gives soft reset only across async and V.32 families
// - Writes to address 0x06 go to the converter output sample
// - Writes to address 0x07 go to the resampler input sample
// - Address 0x08 reads the latest converter input sample
// - Address 0x09 reads the latest resampler output sample
// - Five-bit address; six control registers; 0x0A to 0x1F reserved
// - A register changes only after both words arrive complete
// - Device sends address word, bits 5 to 15 zero, then contents
// - Read answer follows any transfer already under way
// - Incoming data and frame sync sampled on serial clock fall
// - Frame sync ignored during a word until its last bit
// - Outgoing sync and data change on serial clock rise
// - Outgoing sync pulses one bit cycle before each word
// - All words go most significant bit first
// - Samples sent only when running; converter beats resampler
// - Device reset clears all control registers to zero
// - A word ready during a transfer waits for it to end
`timescale 1ns/1ps

module mas_serial_port
  import mas_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Serial link to the host
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_IN_LINE,
  input wire logic SERIAL_IN_FRAME_SYNC,
  output logic SERIAL_OUT_LINE,
  output logic SERIAL_OUT_FRAME_SYNC,
  // Sample paths
  output mas_sample_type DAC_SAMPLE,
  output mas_sample_type INTERP_IN_SAMPLE,
  input wire mas_sample_type ADC_SAMPLE,
  input wire mas_sample_type INTERP_OUT_SAMPLE,
  // Configuration
  output mas_ctrl_type CONTROL,
  output logic SOFT_RESET
);

  // ===========================================================
  // Decoding helpers
  function automatic logic v32_family(input logic [15:0] cfg);
    v32_family = cfg[OP_LSB + OP_V32_BIT];
  endfunction

  function automatic logic reg0_restart(input logic [15:0] old_v,
                                        input logic [15:0] new_v);
    reg0_restart = (old_v[SR_LSB +: SR_BITS] != new_v[SR_LSB +: SR_BITS])
      || (old_v[TS_LSB +: TS_BITS] != new_v[TS_LSB +: TS_BITS])
      || (v32_family(old_v) != v32_family(new_v));
  endfunction

  function automatic logic reg1_restart(input logic [15:0] old_v,
                                        input logic [15:0] new_v);
    reg1_restart = (old_v[FB_LSB +: FB_BITS] != new_v[FB_LSB +: FB_BITS])
      || (old_v[RATE_SCALE_EIGHT_SEVENTHS_BIT] != new_v[RATE_SCALE_EIGHT_SEVENTHS_BIT]);
  endfunction

  // ===========================================================
  // Pin synchronisers and edge finding
  logic [1:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic [1:0] fs_sync;
  logic [1:0] next_sclk_sync;
  logic [1:0] next_sdi_sync;
  logic [1:0] next_fs_sync;
  logic sclk_prev;
  logic next_sclk_prev;
  logic sclk_fall;
  logic sclk_rise;

  always_comb begin
    next_sclk_sync = {sclk_sync[0], SERIAL_CLOCK};
    next_sdi_sync = {sdi_sync[0], SERIAL_IN_LINE};
    next_fs_sync = {fs_sync[0], SERIAL_IN_FRAME_SYNC};
    next_sclk_prev = sclk_sync[1];
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sclk_sync <= 2'h0;
      sdi_sync <= 2'h0;
      fs_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_sync <= next_sclk_sync;
      sdi_sync <= next_sdi_sync;
      fs_sync <= next_fs_sync;
      sclk_prev <= next_sclk_prev;
    end
  end

  assign sclk_fall = sclk_prev & ~sclk_sync[1];
  assign sclk_rise = ~sclk_prev & sclk_sync[1];

  // ===========================================================
  // Word receiver and address/data pairing
  mas_sample_type rx_word;
  logic data_phase;
  logic next_data_phase;
  logic [15:0] addr_word;
  logic [15:0] next_addr_word;
  logic [4:0] wr_addr;
  logic wr_en;
  logic rd_req;

  mas_word_rx u_rx (
    .clk(SYS_CLK),
    .reset(RESET),
    .fall(sclk_fall),
    .serial_in_line(sdi_sync[1]),
    .fs(fs_sync[1]),
    .word(rx_word)
  );

  always_comb begin
    next_data_phase = data_phase;
    next_addr_word = addr_word;
    if (rx_word.valid) begin
      next_data_phase = ~data_phase;
      if (!data_phase) begin
        next_addr_word = rx_word.data;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      data_phase <= 1'b0;
      addr_word <= 16'h0000;
    end else begin
      data_phase <= next_data_phase;
      addr_word <= next_addr_word;
    end
  end

  assign wr_addr = addr_word[ADDR_BITS-1:0];
  assign wr_en = rx_word.valid & data_phase & ~addr_word[RW_BIT];
  assign rd_req = rx_word.valid & data_phase & addr_word[RW_BIT];

  // ===========================================================
  // Register file and soft reset
  mas_ctrl_type next_ctrl;
  mas_sample_type next_dac;
  mas_sample_type next_interp_in;
  logic [15:0] adc_reg;
  logic [15:0] next_adc_reg;
  logic [15:0] iout_reg;
  logic [15:0] next_iout_reg;
  logic next_soft;
  logic operating;

  assign operating = CONTROL.bypass_powerdown_config[DIGITAL_POWERDOWN_RELEASE_BIT];

  always_comb begin
    next_ctrl = CONTROL;
    next_dac = DAC_SAMPLE;
    next_dac.valid = 1'b0;
    next_interp_in = INTERP_IN_SAMPLE;
    next_interp_in.valid = 1'b0;
    next_adc_reg = adc_reg;
    next_iout_reg = iout_reg;
    next_soft = 1'b0;
    if (ADC_SAMPLE.valid) begin
      next_adc_reg = ADC_SAMPLE.data;
    end
    if (INTERP_OUT_SAMPLE.valid) begin
      next_iout_reg = INTERP_OUT_SAMPLE.data;
    end
    if (wr_en) begin
      case (wr_addr)
        ADDR_CTRL0: begin
          next_ctrl.rate_and_mode_config = rx_word.data;
          next_soft = operating
            && reg0_restart(CONTROL.rate_and_mode_config,
                            rx_word.data);
        end
        ADDR_CTRL1: begin
          next_ctrl.bypass_powerdown_config = rx_word.data;
          next_soft = operating
            && reg1_restart(CONTROL.bypass_powerdown_config,
                            rx_word.data);
        end
        ADDR_CTRL2: begin
          next_ctrl.receive_bit_baud_select = rx_word.data;
        end
        ADDR_CTRL3: begin
          next_ctrl.transmit_bit_baud_select = rx_word.data;
        end
        ADDR_CTRL4: begin
          next_ctrl.receive_phase_adjust = rx_word.data;
        end
        ADDR_CTRL5: begin
          next_ctrl.transmit_phase_adjust = rx_word.data;
        end
        ADDR_DAC_IN: begin
          next_dac = '{1'b1, rx_word.data};
        end
        ADDR_INTERP_IN: begin
          next_interp_in = '{1'b1, rx_word.data};
        end
        default: begin
          next_ctrl = CONTROL;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      CONTROL <= {6{CTRL_RESET}};
      DAC_SAMPLE <= '{1'b0, 16'h0000};
      INTERP_IN_SAMPLE <= '{1'b0, 16'h0000};
      adc_reg <= 16'h0000;
      iout_reg <= 16'h0000;
      SOFT_RESET <= 1'b0;
    end else begin
      CONTROL <= next_ctrl;
      DAC_SAMPLE <= next_dac;
      INTERP_IN_SAMPLE <= next_interp_in;
      adc_reg <= next_adc_reg;
      iout_reg <= next_iout_reg;
      SOFT_RESET <= next_soft;
    end
  end

  // ===========================================================
  // Readback mux
  function automatic logic [15:0] read_mux(input logic [4:0] addr,
                                           input mas_ctrl_type c,
                                           input logic [15:0] adc,
                                           input logic [15:0] iout);
    case (addr)
      ADDR_CTRL0: read_mux = c.rate_and_mode_config;
      ADDR_CTRL1: read_mux = c.bypass_powerdown_config;
      ADDR_CTRL2: read_mux = c.receive_bit_baud_select;
      ADDR_CTRL3: read_mux = c.transmit_bit_baud_select;
      ADDR_CTRL4: read_mux = c.receive_phase_adjust;
      ADDR_CTRL5: read_mux = c.transmit_phase_adjust;
      ADDR_ADC_OUT: read_mux = adc;
      ADDR_INTERP_OUT: read_mux = iout;
      default: read_mux = CTRL_RESET;
    endcase
  endfunction

  // ===========================================================
  // Outgoing transfer sequencer
  mas_tx_state_type state;
  mas_tx_state_type next_state;
  mas_src_type src;
  mas_src_type next_src;
  logic pend_adc;
  logic pend_iout;
  logic pend_read;
  logic next_pend_adc;
  logic next_pend_iout;
  logic next_pend_read;
  logic [4:0] read_addr;
  logic [4:0] next_read_addr;
  logic [4:0] src_addr;
  logic tx_load;
  logic tx_ready;
  logic [15:0] tx_word;
  logic take;

  always_comb begin
    case (src)
      SRC_READ: src_addr = read_addr;
      SRC_ADC: src_addr = ADDR_ADC_OUT;
      SRC_INTERP: src_addr = ADDR_INTERP_OUT;
      default: src_addr = ADDR_RESERVED;
    endcase
  end

  always_comb begin
    next_state = state;
    next_src = src;
    tx_load = 1'b0;
    tx_word = 16'h0000;
    take = 1'b0;
    case (state)
      TX_IDLE: begin
        if (tx_ready) begin
          if (pend_read) begin
            next_src = SRC_READ;
            next_state = TX_ADDR;
          end else if (pend_adc && operating) begin
            next_src = SRC_ADC;
            next_state = TX_ADDR;
          end else if (pend_iout && operating) begin
            next_src = SRC_INTERP;
            next_state = TX_ADDR;
          end
        end
      end
      TX_ADDR: begin
        if (tx_ready) begin
          tx_load = 1'b1;
          tx_word = {{(WORD_BITS-ADDR_BITS){1'b0}}, src_addr};
          next_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_ready) begin
          tx_load = 1'b1;
          take = 1'b1;
          tx_word = read_mux(src_addr, CONTROL, adc_reg, iout_reg);
          next_state = TX_IDLE;
        end
      end
      default: begin
        next_state = TX_IDLE;
      end
    endcase
    next_pend_read = (pend_read & ~(take && src == SRC_READ)) | rd_req;
    next_pend_adc = (pend_adc & ~(take && src == SRC_ADC))
      | (ADC_SAMPLE.valid & operating);
    next_pend_iout = (pend_iout & ~(take && src == SRC_INTERP))
      | (INTERP_OUT_SAMPLE.valid & operating);
    next_read_addr = rd_req ? wr_addr : read_addr;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state <= TX_IDLE;
      src <= SRC_READ;
      pend_read <= 1'b0;
      pend_adc <= 1'b0;
      pend_iout <= 1'b0;
      read_addr <= 5'h00;
    end else begin
      state <= next_state;
      src <= next_src;
      pend_read <= next_pend_read;
      pend_adc <= next_pend_adc;
      pend_iout <= next_pend_iout;
      read_addr <= next_read_addr;
    end
  end

  mas_word_tx u_tx (
    .clk(SYS_CLK),
    .reset(RESET),
    .rise(sclk_rise),
    .load(tx_load),
    .word(tx_word),
    .ready(tx_ready),
    .serial_out_line(SERIAL_OUT_LINE),
    .serial_out_frame_sync(SERIAL_OUT_FRAME_SYNC)
  );

  // ===========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_pair_done;
    rx_word.valid && data_phase;
  endsequence
  sequence s_dac_write;
    wr_en && wr_addr == ADDR_DAC_IN;
  endsequence

  property p_reset_clear;
    $past(RESET) |-> CONTROL == {6{CTRL_RESET}};
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control registers not cleared by reset");

  property p_soft_keeps;
    SOFT_RESET |=> $stable(CONTROL);
  endproperty
  a_soft_keeps: assert property (p_soft_keeps)
    else $error("soft reset disturbed the control registers");

  property p_rate_restart;
    (wr_en && wr_addr == ADDR_CTRL0 && operating
      && rx_word.data[SR_LSB +: SR_BITS]
         != CONTROL.rate_and_mode_config[SR_LSB +: SR_BITS])
      |=> SOFT_RESET;
  endproperty
  a_rate_restart: assert property (p_rate_restart)
    else $error("sample rate change gave no soft reset");

  property p_mode_quiet;
    (wr_en && wr_addr == ADDR_CTRL0 && ((rx_word.data
      ^ CONTROL.rate_and_mode_config) & ~MODE_LOW_MASK) == 16'h0000)
      |=> !SOFT_RESET;
  endproperty
  a_mode_quiet: assert property (p_mode_quiet)
    else $error("mode change inside one family gave a soft reset");

  property p_dac_write;
    s_dac_write |=> DAC_SAMPLE.valid
      && DAC_SAMPLE.data == $past(rx_word.data) ##1 !DAC_SAMPLE.valid;
  endproperty
  a_dac_write: assert property (p_dac_write)
    else $error("converter sample write not passed on once");

  property p_interp_write;
    (wr_en && wr_addr == ADDR_INTERP_IN) |=> INTERP_IN_SAMPLE.valid
      && INTERP_IN_SAMPLE.data == $past(rx_word.data);
  endproperty
  a_interp_write: assert property (p_interp_write)
    else $error("resampler sample write not passed on");

  property p_adc_hold;
    ADC_SAMPLE.valid |=> adc_reg == $past(ADC_SAMPLE.data);
  endproperty
  a_adc_hold: assert property (p_adc_hold)
    else $error("converter input sample not held");

  property p_reserved;
    (wr_en && wr_addr >= ADDR_RESERVED) |=> $stable(CONTROL)
      && !DAC_SAMPLE.valid && !INTERP_IN_SAMPLE.valid;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved address write had an effect");

  property p_write_after_pair;
    $rose(DAC_SAMPLE.valid) |-> $past(rx_word.valid && data_phase);
  endproperty
  a_write_after_pair: assert property (p_write_after_pair)
    else $error("register written before the data word ended");

  property p_addr_zero;
    (tx_load && state == TX_ADDR) |-> tx_word[RW_BIT:ADDR_BITS] == '0;
  endproperty
  a_addr_zero: assert property (p_addr_zero)
    else $error("outgoing address word has stray bits");

  property p_adc_first;
    (state == TX_IDLE && tx_ready && !pend_read && pend_adc && pend_iout
      && operating) |=> src == SRC_ADC && state == TX_ADDR;
  endproperty
  a_adc_first: assert property (p_adc_first)
    else $error("resampler sample sent ahead of converter sample");

endmodule

// file: test/mas_host_model.sv
// Purpose: Host side of the serial link for the port bench
// Assumes: Host makes the serial clock and drives on its rise
// Notes: Clock runs only while run is high
`timescale 1ns/1ps

module mas_host_model (
  // Link
  output logic sclk,
  output logic serial_in_line,
  output logic serial_in_frame_sync,
  input wire logic serial_out_line,
  input wire logic serial_out_frame_sync,
  // Control
  input wire logic run
);
  logic [15:0] sh;
  int cnt = 0;
  logic [15:0] got[$];
  // ==========================================================
  // Clock and sender
  initial begin
    sclk = 0;
    serial_in_line = 0;
    serial_in_frame_sync = 0;
  end
  always #62.5 if (run || sclk) sclk = ~sclk;
  task automatic send(input logic [15:0] w);
    @(posedge sclk) #5 serial_in_frame_sync = 1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge sclk) #5 serial_in_frame_sync = 0;
      serial_in_line = w[i];
    end
    @(posedge sclk) #5 serial_in_line = ~serial_in_line;
  endtask
  // ==========================================================
  // Receiver of device words
  always @(negedge sclk) begin
    if (cnt > 0) begin
      sh = {sh[14:0], serial_out_line};
      cnt = cnt - 1;
      if (cnt == 0) got.push_back(sh);
    end else if (serial_out_frame_sync) cnt = 16;
  end
endmodule

// file: test/tb_mas_serial_port.sv
// Purpose: Self-checking bench of the serial register port
// Assumes: Host model drives the link pins
// Notes: Sample sources driven by the bench
`timescale 1ns/1ps

module tb_mas_serial_port
  import mas_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  logic run = 0;
  wire sclk, serial_in_line, serial_in_frame_sync;
  logic serial_out_line, serial_out_frame_sync, sr;
  mas_sample_type dac, iin;
  mas_sample_type adc = '0;
  mas_sample_type iout = '0;
  mas_ctrl_type ctrl;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int srn = 0;
  int dvn = 0;
  // ==========================================================
  // Clock, timeout and pulse counters
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (sr === 1'b1) srn++;
    if (dac.valid === 1'b1) dvn++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  mas_host_model h (.sclk(sclk), .serial_in_line(serial_in_line), .serial_in_frame_sync(serial_in_frame_sync), .serial_out_line(serial_out_line),
    .serial_out_frame_sync(serial_out_frame_sync), .run(run));
  mas_serial_port dut (.SYS_CLK(clk), .RESET(rst), .SERIAL_CLOCK(sclk),
    .SERIAL_IN_LINE(serial_in_line), .SERIAL_IN_FRAME_SYNC(serial_in_frame_sync),
    .SERIAL_OUT_LINE(serial_out_line), .SERIAL_OUT_FRAME_SYNC(serial_out_frame_sync),
    .DAC_SAMPLE(dac), .INTERP_IN_SAMPLE(iin), .ADC_SAMPLE(adc),
    .INTERP_OUT_SAMPLE(iout), .CONTROL(ctrl), .SOFT_RESET(sr));
  // ==========================================================
  // Shared tasks
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    h.send({11'h000, a});
    h.send(d);
    repeat (20) @(posedge clk);
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    int n;
    n = h.got.size();
    h.send({1'b1, 10'h000, a});
    h.send(16'h5a5a);
    for (int i = 0; i < 3000 && h.got.size() < n + 2; i++) @(posedge clk);
    chk("read addr", {11'h000, a}, h.got[n]);
    chk("read data", e, h.got[n + 1]);
  endtask
  task pulse(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk) #1 adc = {1'b1, a};
    iout = {1'b1, b};
    @(posedge clk) #1 adc.valid = 0;
    iout.valid = 0;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset();
    for (int i = 0; i < 6; i++) begin
      chk("ctrl", 16'h0000, ctrl[i*16 +: 16]);
    end
    $display("test reset done");
  endtask
  task t_write();
    wr(ADDR_CTRL2, 16'h0031);
    chk("reg2", 16'h0031, ctrl.receive_bit_baud_select);
    wr(ADDR_DAC_IN, 16'h8001);
    chk("dac", 16'h8001, dac.data);
    chk("dac pulses", 16'h0001, dvn[15:0]);
    wr(ADDR_INTERP_IN, 16'h7ffe);
    chk("interp", 16'h7ffe, iin.data);
    wr(ADDR_ADC_OUT, 16'hffff);
    wr(ADDR_RESERVED, 16'hffff);
    rd(ADDR_CTRL2, 16'h0031);
    rd(ADDR_ADC_OUT, 16'h0000);
    rd(ADDR_DAC_IN, 16'h0000);
    rd(5'h1f, 16'h0000);
    chk("soft resets", 16'h0000, srn[15:0]);
    $display("test write done");
  endtask
  task t_samples();
    int n;
    n = h.got.size();
    pulse(16'h1111, 16'h2222);
    repeat (600) @(posedge clk);
    chk("dropped", n[15:0], 16'(h.got.size()));
    wr(ADDR_CTRL1, 16'h0018);
    pulse(16'h1234, 16'habcd);
    for (int i = 0; i < 3000 && h.got.size() < n + 4; i++) @(posedge clk);
    chk("first addr", 16'h0008, h.got[n]);
    chk("adc", 16'h1234, h.got[n + 1]);
    chk("second addr", 16'h0009, h.got[n + 2]);
    chk("resampler", 16'habcd, h.got[n + 3]);
    $display("test samples done");
  endtask
  task t_soft();
    wr(ADDR_CTRL0, 16'h0001);
    chk("same family", 16'h0000, srn[15:0]);
    wr(ADDR_CTRL0, 16'h0005);
    chk("to v32", 16'h0001, srn[15:0]);
    wr(ADDR_CTRL0, 16'h000d);
    chk("rate", 16'h0002, srn[15:0]);
    wr(ADDR_CTRL1, 16'h0019);
    chk("bypass", 16'h0003, srn[15:0]);
    chk("kept", 16'h0031, ctrl.receive_bit_baud_select);
    chk("reg0", 16'h000d, ctrl.rate_and_mode_config);
    wr(ADDR_CTRL0, 16'h002d);
    chk("sync rate", 16'h0004, srn[15:0]);
    wr(ADDR_CTRL0, 16'h0029);
    chk("to async", 16'h0005, srn[15:0]);
    wr(ADDR_CTRL1, 16'h0039);
    chk("eight sevenths", 16'h0006, srn[15:0]);
    chk("reg1", 16'h0039, ctrl.bypass_powerdown_config);
    chk("reg0 kept", 16'h0029, ctrl.rate_and_mode_config);
    $display("test soft done");
  endtask
  task results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    run = 1;
    t_reset();
    t_write();
    t_samples();
    t_soft();
    run = 0;
    results();
  end
endmodule
